//--- src/saxfl_axis.sv
`timescale 1ns/1ps
// Notes on behaviour
// - with hard overtravel enabled, sample limit inputs and fault on active input
// - hard overtravel checking off after reset; limits ignored while off
// - limit switch checking only for linear servo axes
// - one drive fault input per axis, watched only while its check enable is set
// - normally closed: drive holds input active; inactive input is a drive fault
// - normally closed is default; cleared sense makes active input the fault
// - two status selectors per axis, 0 none and 1 to 13 the listed sources
// - each selected source is sent with actual position every coarse update
// - unselected status values stay as a stale static copy
// - polarity bit 0 inverts encoder feedback sign
// - polarity bit 1 inverts servo output sign; bits 2 to 31 reserved
// - topology chosen from loop configuration and drive type together
// - position mode, torque drive: full position loop with both offsets
// - velocity mode, torque drive: planner velocity command plus both offsets
// - position mode, velocity drive: no inner velocity loop, torque offset ignored
// - offsets come from host settings and take effect at next update
// - commands and offsets refreshed once per coarse update, command from planner
// - fault word: soft overtravel bit 0, drive check bit 1, sense bit 2
// - drive type 0 torque, 1 velocity; velocity disables inner velocity loop
module saxfl_axis
  import saxfl_pkg::*;
#(
  parameter int COARSE_CYCLES = COARSE_CYC
) (
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // host settings
  input wire logic HARD_OT_EN_IN,
  input wire logic LINEAR_AXIS_IN,
  input wire logic [1:0] AXIS_TYPE_IN,
  input wire logic [3:0] LOOP_CFG_IN,
  input wire logic DRIVE_TYPE_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] FAULT_CFG_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] INFO_SEL_A_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] INFO_SEL_B_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] POLARITY_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] VEL_OFFSET_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] TRQ_OFFSET_IN,
  // motion planner and loop signals
  input wire logic [saxfl_pkg::DATA_W-1:0] PLAN_POS_CMD_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] PLAN_VEL_CMD_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] ENCODER_POS_IN,
  input wire logic [saxfl_pkg::DATA_W-1:0] LOOP_OUTPUT_IN,
  input wire logic [saxfl_pkg::NUM_SRC*saxfl_pkg::DATA_W-1:0] STATUS_SRC_IN,
  // pins toward drive and switches
  input wire logic POS_LIMIT_IN,
  input wire logic NEG_LIMIT_IN,
  input wire logic DRIVE_FAULT_IN,
  // outputs
  output logic POS_HARD_OT_OUT,
  output logic NEG_HARD_OT_OUT,
  output logic DRIVE_FAULT_OUT,
  output logic UPDATE_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] ACTUAL_POS_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] INFO_A_OUT,
  output logic INFO_A_VALID_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] INFO_B_OUT,
  output logic INFO_B_VALID_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] SERVO_OUT,
  output logic [1:0] TOPOLOGY_OUT,
  output logic INNER_VEL_LOOP_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] LOOP_POS_CMD_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] LOOP_VEL_CMD_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] LOOP_VEL_OFS_OUT,
  output logic [saxfl_pkg::DATA_W-1:0] LOOP_TRQ_OFS_OUT
);
  import saxfl_pkg::*;

  logic tick;
  logic [DATA_W-1:0] sel_a_val;
  logic [DATA_W-1:0] sel_b_val;
  logic sel_a_ok;
  logic sel_b_ok;
  logic drive_chk_en;
  logic drive_nc;
  logic drive_flt_next;
  logic limit_ok;
  saxfl_topo_e topo_next;

  // two's complement sign flip used for both polarity controls
  function automatic logic [DATA_W-1:0] flip(input logic [DATA_W-1:0] v, input logic inv);
    flip = inv ? (~v + 32'h1) : v;
  endfunction

  saxfl_tick #(
    .PERIOD(COARSE_CYCLES)
  ) u_tick (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .tick_out(tick)
  );

  saxfl_sel u_sel_a (
    .sel_in(INFO_SEL_A_IN[SEL_W-1:0]),
    .src_in(STATUS_SRC_IN),
    .val_out(sel_a_val),
    .valid_out(sel_a_ok)
  );

  saxfl_sel u_sel_b (
    .sel_in(INFO_SEL_B_IN[SEL_W-1:0]),
    .src_in(STATUS_SRC_IN),
    .val_out(sel_b_val),
    .valid_out(sel_b_ok)
  );

  // only the low nibble codes a source; higher bits make the code invalid
  logic sel_a_hi;
  logic sel_b_hi;
  assign sel_a_hi = |INFO_SEL_A_IN[DATA_W-1:SEL_W];
  assign sel_b_hi = |INFO_SEL_B_IN[DATA_W-1:SEL_W];

  // fault word decode
  assign drive_chk_en = FAULT_CFG_IN[FLT_DRV_CHK_BIT];
  assign drive_nc = FAULT_CFG_IN[FLT_DRV_NC_BIT];
  // limit checks apply to linear servo axes only
  assign limit_ok = HARD_OT_EN_IN && LINEAR_AXIS_IN && (AXIS_TYPE_IN == AXIS_SERVO);

  // normally closed: missing signal is the fault; open sense: present signal
  always_comb begin
    drive_flt_next = 1'b0;
    if (drive_chk_en) begin
      drive_flt_next = drive_nc ? !DRIVE_FAULT_IN : DRIVE_FAULT_IN;
    end
  end

  // hard overtravel sampled each coarse update; disabled check clears faults
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      POS_HARD_OT_OUT <= 1'b0;
      NEG_HARD_OT_OUT <= 1'b0;
    end else if (!limit_ok) begin
      POS_HARD_OT_OUT <= 1'b0;
      NEG_HARD_OT_OUT <= 1'b0;
    end else if (tick) begin
      POS_HARD_OT_OUT <= POS_LIMIT_IN;
      NEG_HARD_OT_OUT <= NEG_LIMIT_IN;
    end
  end

  // drive fault watched every cycle, a short drop-out is caught too
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      DRIVE_FAULT_OUT <= 1'b0;
    end else begin
      DRIVE_FAULT_OUT <= drive_flt_next;
    end
  end

  // topology from loop configuration and drive type
  always_comb begin
    topo_next = SAXFL_TOPO_OFF;
    if (AXIS_TYPE_IN == AXIS_SERVO) begin
      case (LOOP_CFG_IN)
        LOOP_POS_SERVO: begin
          topo_next = (DRIVE_TYPE_IN == DRIVE_VELOCITY) ? SAXFL_TOPO_POS_VEL
                                                       : SAXFL_TOPO_POS_TRQ;
        end
        LOOP_VEL_SERVO: begin
          topo_next = (DRIVE_TYPE_IN == DRIVE_TORQUE) ? SAXFL_TOPO_VEL_TRQ
                                                     : SAXFL_TOPO_OFF;
        end
        default: begin
          topo_next = SAXFL_TOPO_OFF;
        end
      endcase
    end
  end

  // topology and inner loop enable follow settings directly
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      TOPOLOGY_OUT <= 2'h0;
      INNER_VEL_LOOP_OUT <= 1'b0;
    end else begin
      TOPOLOGY_OUT <= topo_next;
      INNER_VEL_LOOP_OUT <= (DRIVE_TYPE_IN == DRIVE_TORQUE) &&
                            (topo_next != SAXFL_TOPO_OFF);
    end
  end

  // loop inputs latched once per coarse update so a host write lands next update
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      LOOP_POS_CMD_OUT <= '0;
      LOOP_VEL_CMD_OUT <= '0;
      LOOP_VEL_OFS_OUT <= '0;
      LOOP_TRQ_OFS_OUT <= '0;
    end else if (tick) begin
      LOOP_VEL_OFS_OUT <= VEL_OFFSET_IN;
      case (topo_next)
        SAXFL_TOPO_POS_TRQ: begin
          LOOP_POS_CMD_OUT <= PLAN_POS_CMD_IN;
          LOOP_VEL_CMD_OUT <= '0;
          LOOP_TRQ_OFS_OUT <= TRQ_OFFSET_IN;
        end
        SAXFL_TOPO_VEL_TRQ: begin
          LOOP_POS_CMD_OUT <= '0;
          LOOP_VEL_CMD_OUT <= PLAN_VEL_CMD_IN;
          LOOP_TRQ_OFS_OUT <= TRQ_OFFSET_IN;
        end
        SAXFL_TOPO_POS_VEL: begin
          LOOP_POS_CMD_OUT <= PLAN_POS_CMD_IN;
          LOOP_VEL_CMD_OUT <= '0;
          LOOP_TRQ_OFS_OUT <= '0;
        end
        default: begin
          LOOP_POS_CMD_OUT <= '0;
          LOOP_VEL_CMD_OUT <= '0;
          LOOP_TRQ_OFS_OUT <= '0;
        end
      endcase
    end
  end

  // servo output polarity applied every cycle, it drives the amplifier
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      SERVO_OUT <= '0;
    end else begin
      SERVO_OUT <= flip(LOOP_OUTPUT_IN, POLARITY_IN[POL_SERVO_BIT]);
    end
  end

  // periodic packet: position plus selected status, values held between ticks
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      UPDATE_OUT <= 1'b0;
      ACTUAL_POS_OUT <= '0;
      INFO_A_OUT <= '0;
      INFO_A_VALID_OUT <= 1'b0;
      INFO_B_OUT <= '0;
      INFO_B_VALID_OUT <= 1'b0;
    end else begin
      UPDATE_OUT <= tick;
      if (tick) begin
        ACTUAL_POS_OUT <= flip(ENCODER_POS_IN, POLARITY_IN[POL_FDBK_BIT]);
        INFO_A_VALID_OUT <= sel_a_ok && !sel_a_hi;
        INFO_B_VALID_OUT <= sel_b_ok && !sel_b_hi;
        // unselected channel keeps its last value as a stale copy
        if (sel_a_ok && !sel_a_hi) begin
          INFO_A_OUT <= sel_a_val;
        end
        if (sel_b_ok && !sel_b_hi) begin
          INFO_B_OUT <= sel_b_val;
        end
      end
    end
  end

  // hard overtravel: cleared while off, sampled on a tick, held between ticks
  a_limit_off_quiet: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !limit_ok |=> !POS_HARD_OT_OUT && !NEG_HARD_OT_OUT)
    else $error("hard overtravel fault while checking off");
  a_limit_sampled: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && limit_ok |=> POS_HARD_OT_OUT == $past(POS_LIMIT_IN))
    else $error("positive limit not sampled");
  a_neg_sampled: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && limit_ok |=> NEG_HARD_OT_OUT == $past(NEG_LIMIT_IN))
    else $error("negative limit not sampled");
  a_pos_held: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    limit_ok && !tick |=> $stable(POS_HARD_OT_OUT) && $stable(NEG_HARD_OT_OUT))
    else $error("hard overtravel changed between updates");
  a_nonlinear_quiet: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !LINEAR_AXIS_IN |=> !NEG_HARD_OT_OUT)
    else $error("overtravel on non-linear axis");
  a_servo_axis_only: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    AXIS_TYPE_IN != AXIS_SERVO |=> !POS_HARD_OT_OUT && !NEG_HARD_OT_OUT)
    else $error("overtravel on non-servo axis");
  // drive fault sense, both contact types, both input levels
  a_drive_nc_fault: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    drive_chk_en && drive_nc && !DRIVE_FAULT_IN |=> DRIVE_FAULT_OUT)
    else $error("normally closed drive fault missed");
  a_drive_nc_healthy: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    drive_chk_en && drive_nc && DRIVE_FAULT_IN |=> !DRIVE_FAULT_OUT)
    else $error("normally closed healthy drive faulted");
  a_drive_no_fault: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    drive_chk_en && !drive_nc && !DRIVE_FAULT_IN |=> !DRIVE_FAULT_OUT)
    else $error("inverted sense fault wrong");
  a_drive_inv_fault: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    drive_chk_en && !drive_nc && DRIVE_FAULT_IN |=> DRIVE_FAULT_OUT)
    else $error("inverted sense fault missed");
  a_drive_check_off: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !drive_chk_en |=> !DRIVE_FAULT_OUT)
    else $error("drive fault while checking off");
  // periodic packet, selection decode and stale copies
  a_update_period: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    UPDATE_OUT |=> !UPDATE_OUT)
    else $error("update pulse too long");
  a_update_tick: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick |=> UPDATE_OUT)
    else $error("update pulse missing after tick");
  a_info_stale: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !tick |=> $stable(INFO_A_OUT) && $stable(ACTUAL_POS_OUT))
    else $error("status changed between updates");
  a_info_b_stale: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !tick |=> $stable(INFO_B_OUT) && $stable(INFO_A_VALID_OUT) && $stable(INFO_B_VALID_OUT))
    else $error("second status changed between updates");
  a_info_a_sent: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && INFO_SEL_A_IN <= 32'(SEL_MAX) && INFO_SEL_A_IN != 32'(SEL_NONE)
    |=> INFO_A_VALID_OUT)
    else $error("selected status not flagged valid");
  a_info_a_value: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && INFO_SEL_A_IN == 32'h1 |=> INFO_A_OUT == $past(STATUS_SRC_IN[2*DATA_W-1:DATA_W]))
    else $error("selected status value not sent");
  a_info_none: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && INFO_SEL_A_IN == '0 |=> !INFO_A_VALID_OUT)
    else $error("status sent with none selected");
  a_info_a_range: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && INFO_SEL_A_IN > 32'(SEL_MAX) |=> !INFO_A_VALID_OUT)
    else $error("out of range selector sent status");
  a_info_b_range: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && INFO_SEL_B_IN > 32'(SEL_MAX) |=> !INFO_B_VALID_OUT)
    else $error("out of range second selector sent status");
  // polarity of feedback and servo output
  a_feedback_flip: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && POLARITY_IN[POL_FDBK_BIT] |=> ACTUAL_POS_OUT == ~$past(ENCODER_POS_IN) + 32'h1)
    else $error("feedback polarity not inverted");
  a_servo_flip: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    POLARITY_IN[POL_SERVO_BIT] |=> SERVO_OUT == ~$past(LOOP_OUTPUT_IN) + 32'h1)
    else $error("servo polarity not inverted");
  a_servo_plain: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !POLARITY_IN[POL_SERVO_BIT] |=> SERVO_OUT == $past(LOOP_OUTPUT_IN))
    else $error("servo output inverted while polarity clear");
  // topology selection and the loop inputs latched on each tick
  a_topo_pos_trq: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    AXIS_TYPE_IN == AXIS_SERVO && LOOP_CFG_IN == LOOP_POS_SERVO &&
    DRIVE_TYPE_IN == DRIVE_TORQUE |=> TOPOLOGY_OUT == SAXFL_TOPO_POS_TRQ)
    else $error("position torque topology not chosen");
  a_topo_vel_vel: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    AXIS_TYPE_IN == AXIS_SERVO && LOOP_CFG_IN == LOOP_VEL_SERVO &&
    DRIVE_TYPE_IN == DRIVE_VELOCITY |=> TOPOLOGY_OUT == SAXFL_TOPO_OFF)
    else $error("unsupported topology not off");
  a_inner_off_vel: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    DRIVE_TYPE_IN == DRIVE_VELOCITY |=> !INNER_VEL_LOOP_OUT)
    else $error("inner velocity loop with velocity drive");
  a_pos_cmd_taken: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && topo_next == SAXFL_TOPO_POS_TRQ |=> LOOP_POS_CMD_OUT == $past(PLAN_POS_CMD_IN)
    && LOOP_TRQ_OFS_OUT == $past(TRQ_OFFSET_IN))
    else $error("position loop inputs not taken");
  a_vel_cmd_taken: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && topo_next == SAXFL_TOPO_VEL_TRQ |=> LOOP_VEL_CMD_OUT == $past(PLAN_VEL_CMD_IN))
    else $error("planner velocity command not taken");
  a_vel_drive_trq: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick && topo_next == SAXFL_TOPO_POS_VEL |=> LOOP_TRQ_OFS_OUT == '0)
    else $error("torque offset used with velocity drive");
  a_offset_taken: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    tick |=> LOOP_VEL_OFS_OUT == $past(VEL_OFFSET_IN))
    else $error("velocity offset not refreshed");
  a_loop_held: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !tick |=> $stable(LOOP_POS_CMD_OUT) && $stable(LOOP_VEL_CMD_OUT) &&
    $stable(LOOP_VEL_OFS_OUT) && $stable(LOOP_TRQ_OFS_OUT))
    else $error("loop inputs changed between updates");
endmodule

//--- src/saxfl_pkg.sv
package saxfl_pkg;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // fault configuration word fields
  localparam int FLT_SOFT_OT_BIT = 0;
  localparam int FLT_DRV_CHK_BIT = 1;
  localparam int FLT_DRV_NC_BIT = 2;
  localparam logic [31:0] FLT_CFG_RESET = 32'h0000_0004;
  // polarity word fields
  localparam int POL_FDBK_BIT = 0;
  localparam int POL_SERVO_BIT = 1;
  localparam logic [31:0] POL_RESET = 32'h0000_0000;
  // status source encodings
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'hD;
  localparam int NUM_SRC = 14;
  // axis type and loop configuration encodings
  localparam logic [1:0] AXIS_UNUSED = 2'h0;
  localparam logic [1:0] AXIS_FDBK = 2'h1;
  localparam logic [1:0] AXIS_SERVO = 2'h2;
  localparam logic [3:0] LOOP_POS_SERVO = 4'h3;
  localparam logic [3:0] LOOP_VEL_SERVO = 4'h8;
  localparam logic DRIVE_TORQUE = 1'b0;
  localparam logic DRIVE_VELOCITY = 1'b1;
  // coarse update period in cycles of the 50 MHz clock
  localparam int CLK_HZ = 50_000_000;
  localparam int COARSE_US = 1000;
  localparam int COARSE_CYC = CLK_HZ / 1_000_000 * COARSE_US;
  typedef enum logic [1:0] {SAXFL_TOPO_OFF, SAXFL_TOPO_POS_TRQ, SAXFL_TOPO_VEL_TRQ,
    SAXFL_TOPO_POS_VEL} saxfl_topo_e;
endpackage

//--- src/saxfl_tick.sv
`timescale 1ns/1ps
// one-cycle pulse every PERIOD cycles
module saxfl_tick #(
  parameter int PERIOD = 50000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);
  logic [31:0] cnt_reg;

  // free-running divider; the pulse marks each coarse update
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 32'h0;
      tick_out <= 1'b0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_reg <= 32'h0;
      tick_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_out <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_out |=> !tick_out)
    else $error("tick pulse longer than one cycle");
endmodule

//--- src/saxfl_sel.sv
`timescale 1ns/1ps
// picks one status source by its selection code
module saxfl_sel
  import saxfl_pkg::*;
(
  input wire logic [SEL_W-1:0] sel_in,
  input wire logic [NUM_SRC*DATA_W-1:0] src_in,
  output logic [DATA_W-1:0] val_out,
  output logic valid_out
);
  // out-of-range codes behave as none so nothing is sent
  always_comb begin
    val_out = '0;
    valid_out = 1'b0;
    if (sel_in != SEL_NONE && sel_in <= SEL_MAX) begin
      val_out = src_in[sel_in*DATA_W +: DATA_W];
      valid_out = 1'b1;
    end
  end
endmodule

//--- tb/saxfl_drive_model.sv
`timescale 1ns/1ps
// stand-in for the drive contacts and the two limit switches; levels only, no bounce
module saxfl_drive_model (
  input wire logic broken_in,
  input wire logic nc_in,
  input wire logic pos_hit_in,
  input wire logic neg_hit_in,
  output logic fault_pin_out,
  output logic pos_sw_out,
  output logic neg_sw_out
);
  // a normally closed drive holds 24 V while healthy and opens on a fault
  assign fault_pin_out = nc_in ? ~broken_in : broken_in;
  // switches close when the axis reaches the end of travel
  assign pos_sw_out = pos_hit_in;
  assign neg_sw_out = neg_hit_in;
endmodule

//--- tb/servo_axis_fault_and_loop_config_test.sv
`timescale 1ns/1ps
module servo_axis_fault_and_loop_config_test;
  import saxfl_pkg::*;
  localparam int N = 8;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ot_en = 1'h0, lin = 1'h0, drv = 1'h0, broken = 1'h0, p_hit = 1'h0, n_hit = 1'h0;
  logic [1:0] atype = 2'h0;
  logic [3:0] loop = 4'h0;
  logic [31:0] fcfg = 32'h0, sel_a = 32'h0, sel_b = 32'h0, pol = POL_RESET, vofs = 32'h0;
  logic [31:0] tofs = 32'h0, ppos = 32'h0, pvel = 32'h0, enc = 32'h0, lout = 32'h0;
  logic [NUM_SRC*DATA_W-1:0] src;
  logic fpin, psw, nsw, p_ot, n_ot, d_flt, upd, va, vb, inner;
  logic [31:0] apos, ia, ib, sout, lpc, lvc, lvo, lto;
  logic [1:0] topo;
  int n_fail = 0;
  int comparisons = 0;
  // short coarse period keeps the run small
  saxfl_axis #(.COARSE_CYCLES(N)) i_saxfl_axis (.MCLK_IN(clk), .RESET_N_IN(rst_n),
    .HARD_OT_EN_IN(ot_en), .LINEAR_AXIS_IN(lin), .AXIS_TYPE_IN(atype), .LOOP_CFG_IN(loop),
    .DRIVE_TYPE_IN(drv), .FAULT_CFG_IN(fcfg), .INFO_SEL_A_IN(sel_a), .INFO_SEL_B_IN(sel_b),
    .POLARITY_IN(pol), .VEL_OFFSET_IN(vofs), .TRQ_OFFSET_IN(tofs), .PLAN_POS_CMD_IN(ppos),
    .PLAN_VEL_CMD_IN(pvel), .ENCODER_POS_IN(enc), .LOOP_OUTPUT_IN(lout), .STATUS_SRC_IN(src),
    .POS_LIMIT_IN(psw), .NEG_LIMIT_IN(nsw), .DRIVE_FAULT_IN(fpin), .POS_HARD_OT_OUT(p_ot),
    .NEG_HARD_OT_OUT(n_ot), .DRIVE_FAULT_OUT(d_flt), .UPDATE_OUT(upd), .ACTUAL_POS_OUT(apos),
    .INFO_A_OUT(ia), .INFO_A_VALID_OUT(va), .INFO_B_OUT(ib), .INFO_B_VALID_OUT(vb),
    .SERVO_OUT(sout), .TOPOLOGY_OUT(topo), .INNER_VEL_LOOP_OUT(inner), .LOOP_POS_CMD_OUT(lpc),
    .LOOP_VEL_CMD_OUT(lvc), .LOOP_VEL_OFS_OUT(lvo), .LOOP_TRQ_OFS_OUT(lto));
  // contact type of the model follows the configured sense
  saxfl_drive_model i_saxfl_drive_model (.broken_in(broken), .nc_in(fcfg[FLT_DRV_NC_BIT]),
    .pos_hit_in(p_hit), .neg_hit_in(n_hit), .fault_pin_out(fpin), .pos_sw_out(psw),
    .neg_sw_out(nsw));
  // 50 MHz
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for the coarse update pulse, sampled just after the edge
  task automatic wait_upd;
    for (int i = 0; i < 4 * N; i++) begin
      @(posedge clk);
      #1;
      if (upd === 1'h1) return;
    end
    n_fail++;
    $display("wrong value update pulse expected 1 seen 0");
  endtask
  // two updates, so the second surely sampled the new settings
  task automatic settle;
    wait_upd();
    wait_upd();
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_hard_ot;
    @(posedge clk);
    p_hit <= 1'h1;
    atype <= AXIS_SERVO;
    lin <= 1'h1;
    settle();
    chk("pos ot while off", 32'h0, p_ot);
    @(posedge clk);
    ot_en <= 1'h1;
    settle();
    chk("pos ot", 32'h1, p_ot);
    chk("neg ot", 32'h0, n_ot);
    @(posedge clk);
    p_hit <= 1'h0;
    n_hit <= 1'h1;
    atype <= AXIS_FDBK;
    settle();
    chk("neg ot feedback axis", 32'h0, n_ot);
    @(posedge clk);
    atype <= AXIS_SERVO;
    settle();
    chk("neg ot", 32'h1, n_ot);
    chk("pos ot released", 32'h0, p_ot);
    $display("test hard overtravel done");
  endtask
  task automatic t_drive;
    @(posedge clk);
    fcfg <= FLT_CFG_RESET; // default sense, checking still off
    broken <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("drive fault unchecked", 32'h0, d_flt);
    @(posedge clk);
    fcfg <= 32'h0000_0006;
    broken <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("drive healthy closed", 32'h0, d_flt);
    @(posedge clk);
    broken <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("drive opened", 32'h1, d_flt);
    // inverted sense: the model now closes its contact on a fault
    @(posedge clk);
    fcfg <= 32'h0000_0002;
    repeat (2) @(posedge clk);
    #1;
    chk("drive closed on fault", 32'h1, d_flt);
    @(posedge clk);
    broken <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("drive healthy open", 32'h0, d_flt);
    $display("test drive fault done");
  endtask
  task automatic t_info;
    chk("info a none", 32'h0, va);
    for (int k = 1; k <= 13; k++) begin
      @(posedge clk);
      sel_a <= 32'(k);
      sel_b <= 32'(14 - k);
      settle();
      chk("info a", src[k*32+:32], ia);
      chk("info a valid", 32'h1, va);
      chk("info b", src[(14-k)*32+:32], ib);
    end
    // code 14 and a code with upper bits set both select nothing
    @(posedge clk);
    sel_a <= 32'h0000_000E;
    sel_b <= 32'h0001_0001;
    src[32+:32] <= 32'h5555_0001;
    settle();
    chk("info a valid", 32'h0, va);
    chk("info b valid", 32'h0, vb);
    chk("info b stale", 32'hA000_0001, ib);
    chk("info a stale", 32'hA000_000D, ia);
    $display("test status select done");
  endtask
  task automatic t_polarity;
    @(posedge clk);
    enc <= 32'h0000_0010;
    lout <= 32'h0000_0005;
    pol <= 32'h0000_0003;
    settle();
    chk("actual position", 32'hFFFF_FFF0, apos);
    chk("servo output", 32'hFFFF_FFFB, sout);
    @(posedge clk);
    pol <= 32'hFFFF_FFFC;
    settle();
    chk("actual position", 32'h0000_0010, apos);
    chk("servo output", 32'h0000_0005, sout);
    $display("test polarity done");
  endtask
  task automatic t_loops;
    @(posedge clk);
    ppos <= 32'h0000_1234;
    pvel <= 32'h0000_0567;
    vofs <= 32'h0000_0222;
    tofs <= 32'h0000_0333;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      loop <= (i % 2 == 1) ? LOOP_VEL_SERVO : LOOP_POS_SERVO;
      drv <= (i >= 2) ? DRIVE_VELOCITY : DRIVE_TORQUE;
      settle();
      chk("topology", (i == 3) ? 32'h0 : 32'(i + 1), topo);
      chk("inner loop", 32'(i < 2), inner);
      if (i == 0) chk("position command", 32'h0000_1234, lpc);
      if (i == 1) chk("velocity command", 32'h0000_0567, lvc);
      if (i < 3) chk("velocity offset", 32'h0000_0222, lvo);
      if (i < 3) chk("torque offset", (i == 2) ? 32'h0 : 32'h0000_0333, lto);
    end
    // offsets change mid period: old values until the next update
    @(posedge clk);
    loop <= LOOP_POS_SERVO;
    drv <= DRIVE_TORQUE;
    settle();
    @(posedge clk);
    vofs <= 32'h0000_0777;
    tofs <= 32'h0000_0888;
    repeat (3) @(posedge clk);
    #1;
    chk("offset before update", 32'h0000_0222, lvo);
    wait_upd();
    chk("velocity offset", 32'h0000_0777, lvo);
    chk("torque offset", 32'h0000_0888, lto);
    $display("test loop topology done");
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    $display("wrong value watchdog expected finish seen timeout");
    test_done();
  end
  initial begin
    for (int k = 0; k < NUM_SRC; k++) src[k*32+:32] = 32'hA000_0000 + 32'(k);
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_hard_ot();
    t_drive();
    t_info();
    t_polarity();
    t_loops();
    test_done();
  end
endmodule
